// [rtl/eaw_eeprom.sv]
`timescale 1ns/100ps
`include "eaw_params.svh"
module eaw_eeprom import eaw_pkg::*; #(
    parameter int ADDR_W       = 11,
    parameter int WRITE_CYCLES = `EAW_EE_WRITE_CYCLES
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              wr_req,
    input  wire logic              write_enable,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wr_data,
    output logic      [7:0]        rd_data,
    output logic                   ready
);
    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

    logic [7:0]        mem [0:(1<<ADDR_W)-1];
    eaw_ee_state_t     state_reg, state_next;
    logic [CNT_W-1:0]  cnt_reg, cnt_next;
    logic [ADDR_W-1:0] waddr_reg, waddr_next;
    logic [7:0]        wdata_reg, wdata_next;
    logic              commit;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        commit     = 1'b0;
        case (state_reg)
            EE_IDLE: begin
                if (wr_req && write_enable) begin
                    state_next = EE_BUSY;
                    cnt_next   = CNT_W'(WRITE_CYCLES - 1);
                    waddr_next = addr;
                    wdata_next = wr_data;
                end
            end
            EE_BUSY: begin
                if (cnt_reg == '0) begin
                    state_next = EE_IDLE;
                    commit     = 1'b1;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: state_next = EE_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= EE_IDLE;
            cnt_reg   <= '0;
            waddr_reg <= '0;
            wdata_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
        end
    end

    // Array is nonvolatile, so reset leaves it alone
    always_ff @(posedge clock) begin
        if (commit) begin
            mem[waddr_reg] <= wdata_reg;
        end
    end

    assign ready   = (state_reg == EE_IDLE);
    // Polling reads see the pending byte with its top bit flipped
    assign rd_data = ready ? mem[addr] : {~wdata_reg[7], wdata_reg[6:0]};

    logic [CNT_W:0] span_reg;
    always_ff @(posedge clock) begin
        if (rst || ready) begin
            span_reg <= '0;
        end else begin
            span_reg <= span_reg + 1'b1;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_write_start;
        ready && wr_req && write_enable;
    endsequence

    a_write_gate: assert property (ready && wr_req && !write_enable |=> ready)
        else $error("eeprom write started without write enable");
    a_write_time: assert property ($rose(ready) |-> span_reg == (CNT_W+1)'(WRITE_CYCLES))
        else $error("eeprom write cycle has wrong length");
    a_busy_flag: assert property (s_write_start |=> !ready)
        else $error("busy not shown after write start");
    a_msb_invert: assert property (s_write_start |=> (rd_data ^ 8'h80) == $past(wr_data))
        else $error("busy read not complemented top bit");
    a_true_data: assert property ($rose(ready) && addr == waddr_reg |-> rd_data == wdata_reg)
        else $error("stored byte wrong after write");
endmodule

// [rtl/eaw_params.svh]
`ifndef EAW_PARAMS_SVH
`define EAW_PARAMS_SVH

// Control register location and internal memory split
`define EAW_WMC_ADDR          8'h96
`define EAW_LOWER_TOP         8'h7f
`define EAW_EE_TOP            16'h07ff

// Control register layout
`define EAW_WMC_RESET         8'h00
`define EAW_WMC_MASK          8'hf9
`define EAW_BIT_WDOG_EN       0
`define EAW_BIT_RESTART       1
`define EAW_BIT_EE_SEL        3
`define EAW_BIT_EE_WE         4
`define EAW_BIT_PSEL_LO       5

// Timing
`define EAW_CLK_NS            50
`define EAW_EE_WRITE_NS       2500000
`define EAW_EE_WRITE_CYCLES   (`EAW_EE_WRITE_NS / `EAW_CLK_NS)
`define EAW_WDOG_BASE_MS      16
`define EAW_WDOG_TICKS_PER_MS 1

`endif

// [rtl/eaw_pkg.sv]
package eaw_pkg;
    typedef enum logic [1:0] {
        EE_IDLE = 2'b01,
        EE_BUSY = 2'b10
    } eaw_ee_state_t;

    typedef enum logic [2:0] {
        RT_RAM = 3'b001,
        RT_WMC = 3'b010,
        RT_SFS = 3'b100
    } eaw_route_t;
endpackage

// [rtl/eaw_top.sv]
`timescale 1ns/100ps
`include "eaw_params.svh"
module eaw_top import eaw_pkg::*; #(
    parameter int EE_WRITE_CYCLES = `EAW_EE_WRITE_CYCLES,
    parameter int WDOG_BASE_TICKS = `EAW_WDOG_BASE_MS * `EAW_WDOG_TICKS_PER_MS
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        id_req,
    input  wire logic        id_we,
    input  wire logic        id_indirect,
    input  wire logic        id_stack,
    input  wire logic [7:0]  id_addr,
    input  wire logic [7:0]  id_wdata,
    output logic      [7:0]  id_rdata,
    output logic             id_rvalid,
    output logic             sfs_ext_req,
    output logic             sfs_ext_we,
    output logic      [7:0]  sfs_ext_addr,
    output logic      [7:0]  sfs_ext_wdata,
    input  wire logic [7:0]  sfs_ext_rdata,
    input  wire logic        xd_req,
    input  wire logic        xd_we,
    input  wire logic [15:0] xd_addr,
    input  wire logic [7:0]  xd_wdata,
    output logic      [7:0]  xd_rdata,
    output logic             xd_rvalid,
    output logic             ext_xd_req,
    output logic             ext_xd_we,
    output logic      [15:0] ext_xd_addr,
    output logic      [7:0]  ext_xd_wdata,
    input  wire logic [7:0]  ext_xd_rdata,
    input  wire logic        wdog_osc_tick,
    input  wire logic        power_down,
    output logic             wdog_cpu_reset,
    output logic             eeprom_done_flag
);
    logic [7:0]  ram [0:255];
    eaw_route_t  route;
    logic        id_is_indirect;
    logic        id_wr_ram;
    logic        id_wr_wmc;
    logic [7:0]  wmc_reg, wmc_next;
    logic        restart_reg, restart_next;
    logic [7:0]  wmc_read;
    logic [7:0]  id_rdata_reg, id_rdata_next;
    logic        id_rvalid_reg, id_rvalid_next;
    logic [7:0]  xd_rdata_reg, xd_rdata_next;
    logic        xd_rvalid_reg, xd_rvalid_next;
    logic        wdog_enable;
    logic        eeprom_select;
    logic        eeprom_write_enable;
    logic [2:0]  wdog_period_sel;
    logic        ee_hit;
    logic        ee_ready;
    logic [7:0]  ee_rdata;

    assign wdog_enable         = wmc_reg[`EAW_BIT_WDOG_EN];
    assign eeprom_select       = wmc_reg[`EAW_BIT_EE_SEL];
    assign eeprom_write_enable = wmc_reg[`EAW_BIT_EE_WE];
    assign wdog_period_sel     = wmc_reg[`EAW_BIT_PSEL_LO +: 3];

    // Internal data space decode
    always_comb begin
        id_is_indirect = id_indirect || id_stack;
        if (!id_is_indirect && id_addr > `EAW_LOWER_TOP) begin
            route = (id_addr == `EAW_WMC_ADDR) ? RT_WMC : RT_SFS;
        end else begin
            route = RT_RAM;
        end
        id_wr_ram = id_req && id_we && (route == RT_RAM);
        id_wr_wmc = id_req && id_we && (route == RT_WMC);
    end

    assign sfs_ext_req   = id_req && (route == RT_SFS);
    assign sfs_ext_we    = id_we;
    assign sfs_ext_addr  = id_addr;
    assign sfs_ext_wdata = id_wdata;

    // Restart bit never stores: it reads back as the done flag
    always_comb begin
        wmc_read                   = wmc_reg & `EAW_WMC_MASK;
        wmc_read[`EAW_BIT_RESTART] = ee_ready;
    end

    always_comb begin
        wmc_next     = wmc_reg;
        restart_next = 1'b0;
        if (id_wr_wmc) begin
            wmc_next     = id_wdata & `EAW_WMC_MASK;
            restart_next = id_wdata[`EAW_BIT_RESTART];
        end
    end

    always_comb begin
        id_rvalid_next = id_req && !id_we;
        id_rdata_next  = id_rdata_reg;
        if (id_req && !id_we) begin
            case (route)
                RT_RAM:  id_rdata_next = ram[id_addr];
                RT_WMC:  id_rdata_next = wmc_read;
                RT_SFS:  id_rdata_next = sfs_ext_rdata;
                default: id_rdata_next = 8'h00;
            endcase
        end
    end

    // Addresses past the EEPROM top fall through to off-chip memory
    always_comb begin
        ee_hit         = eeprom_select && (xd_addr <= `EAW_EE_TOP);
        xd_rvalid_next = xd_req && !xd_we;
        xd_rdata_next  = xd_rdata_reg;
        if (xd_req && !xd_we) begin
            xd_rdata_next = ee_hit ? ee_rdata : ext_xd_rdata;
        end
    end

    assign ext_xd_req   = xd_req && !ee_hit;
    assign ext_xd_we    = xd_we;
    assign ext_xd_addr  = xd_addr;
    assign ext_xd_wdata = xd_wdata;

    always_ff @(posedge clock) begin
        if (rst) begin
            wmc_reg       <= `EAW_WMC_RESET;
            restart_reg   <= 1'b0;
            id_rdata_reg  <= 8'h00;
            id_rvalid_reg <= 1'b0;
            xd_rdata_reg  <= 8'h00;
            xd_rvalid_reg <= 1'b0;
        end else begin
            wmc_reg       <= wmc_next;
            restart_reg   <= restart_next;
            id_rdata_reg  <= id_rdata_next;
            id_rvalid_reg <= id_rvalid_next;
            xd_rdata_reg  <= xd_rdata_next;
            xd_rvalid_reg <= xd_rvalid_next;
        end
    end

    // RAM contents survive reset, as on the real core
    always_ff @(posedge clock) begin
        if (id_wr_ram) begin
            ram[id_addr] <= id_wdata;
        end
    end

    assign id_rdata         = id_rdata_reg;
    assign id_rvalid        = id_rvalid_reg;
    assign xd_rdata         = xd_rdata_reg;
    assign xd_rvalid        = xd_rvalid_reg;
    assign eeprom_done_flag = ee_ready;

    eaw_eeprom #(
        .ADDR_W       (11),
        .WRITE_CYCLES (EE_WRITE_CYCLES)
    ) u_eeprom (
        .clock        (clock),
        .rst          (rst),
        .wr_req       (xd_req && xd_we && ee_hit),
        .write_enable (eeprom_write_enable),
        .addr         (xd_addr[10:0]),
        .wr_data      (xd_wdata),
        .rd_data      (ee_rdata),
        .ready        (ee_ready)
    );

    eaw_wdog #(
        .BASE_TICKS (WDOG_BASE_TICKS),
        .CNT_W      (24)
    ) u_wdog (
        .clock      (clock),
        .rst        (rst),
        .osc_tick   (wdog_osc_tick),
        .enable     (wdog_enable),
        .restart    (restart_reg),
        .power_down (power_down),
        .period_sel (wdog_period_sel),
        .timeout    (wdog_cpu_reset)
    );

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_upper_write;
        id_req && id_we && id_indirect && id_addr > `EAW_LOWER_TOP;
    endsequence

    sequence s_same_read;
        id_req && !id_we && id_is_indirect && id_addr == $past(id_addr);
    endsequence

    a_direct_sfs: assert property (id_req && !id_is_indirect && id_addr > `EAW_LOWER_TOP
        && id_addr != `EAW_WMC_ADDR |-> sfs_ext_req)
        else $error("direct upper access missed register space");
    a_indirect_ram: assert property (id_req && id_is_indirect |-> !sfs_ext_req)
        else $error("indirect access leaked to register space");
    a_upper_store: assert property (s_upper_write ##1 s_same_read |=> id_rdata == $past(id_wdata, 2))
        else $error("upper RAM byte not kept");
    a_xd_offchip: assert property (xd_req && !eeprom_select |-> ext_xd_req && ext_xd_addr == xd_addr)
        else $error("external move not sent off-chip");
    a_xd_eeprom: assert property (xd_req && eeprom_select && xd_addr <= `EAW_EE_TOP |-> !ext_xd_req)
        else $error("eeprom access leaked off-chip");
    a_restart_pulse: assert property (id_wr_wmc && id_wdata[`EAW_BIT_RESTART]
        |=> restart_reg ##1 !restart_reg)
        else $error("restart bit did not self-clear");
    a_done_read: assert property (id_req && !id_we && route == RT_WMC
        |=> id_rdata[`EAW_BIT_RESTART] == $past(ee_ready))
        else $error("done flag read wrong");
    a_enable_bit: assert property (id_wr_wmc |=> wdog_enable == $past(id_wdata[`EAW_BIT_WDOG_EN]))
        else $error("watchdog enable not taken");

    // Pin-level views, so a broken path shows even when the submodules agree with themselves
    localparam int SPAN_W = $clog2(EE_WRITE_CYCLES + 2);

    logic [SPAN_W-1:0] busy_span_reg, busy_span_next;

    always_comb begin
        busy_span_next = '0;
        if (!eeprom_done_flag) begin
            busy_span_next = busy_span_reg + SPAN_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            busy_span_reg <= '0;
        end else begin
            busy_span_reg <= busy_span_next;
        end
    end

    sequence s_ee_write_req;
        xd_req && xd_we && ee_hit && eeprom_done_flag;
    endsequence

    sequence s_ee_read_req;
        xd_req && !xd_we && ee_hit;
    endsequence

    sequence s_off_read_req;
        xd_req && !xd_we && !ee_hit;
    endsequence

    sequence s_sfs_read_req;
        id_req && !id_we && route == RT_SFS;
    endsequence

    a_ee_span: assert property ($rose(eeprom_done_flag)
        |-> busy_span_reg == SPAN_W'(EE_WRITE_CYCLES))
        else $error("eeprom busy time wrong at the pins");
    a_ee_start: assert property (s_ee_write_req ##0 eeprom_write_enable |=> !eeprom_done_flag)
        else $error("eeprom write did not show busy");
    a_ee_gate: assert property (s_ee_write_req ##0 !eeprom_write_enable |=> eeprom_done_flag)
        else $error("eeprom write ran without enable");
    a_ee_rd_path: assert property (s_ee_read_req |=> xd_rvalid && xd_rdata == $past(ee_rdata))
        else $error("eeprom read data not returned");
    a_off_rd_path: assert property (s_off_read_req |=> xd_rvalid && xd_rdata == $past(ext_xd_rdata))
        else $error("off-chip read data not returned");
    a_ee_top_edge: assert property (xd_req && eeprom_select && xd_addr > `EAW_EE_TOP |-> ext_xd_req)
        else $error("address past eeprom top kept on-chip");
    a_sfs_rd_path: assert property (s_sfs_read_req |=> id_rvalid && id_rdata == $past(sfs_ext_rdata))
        else $error("register space read data not returned");
    a_stack_ram: assert property (id_req && id_stack |-> route == RT_RAM && !sfs_ext_req)
        else $error("stack access left upper RAM");
    a_restart_wo: assert property (!wmc_reg[`EAW_BIT_RESTART])
        else $error("restart bit was stored");
    a_read_answer: assert property (id_req && !id_we |=> id_rvalid)
        else $error("internal read not answered");
    a_xread_answer: assert property (xd_req && !xd_we |=> xd_rvalid)
        else $error("external move read not answered");
    // Stay quiet through power down, or the core wakes into a reset
    a_wdog_pd: assert property (power_down |=> !wdog_cpu_reset)
        else $error("watchdog reset during power down");
    a_wdog_single: assert property (wdog_cpu_reset |=> !wdog_cpu_reset)
        else $error("watchdog reset longer than one cycle");
    a_wdog_off: assert property (!wdog_enable |=> !wdog_cpu_reset)
        else $error("disabled watchdog issued reset");
    a_reset_clear: assert property (@(posedge clock) disable iff (1'b0) rst
        |=> wmc_reg == `EAW_WMC_RESET && !wdog_cpu_reset)
        else $error("control register not cleared by reset");
endmodule

// [rtl/eaw_wdog.sv]
`timescale 1ns/100ps
`include "eaw_params.svh"
module eaw_wdog import eaw_pkg::*; #(
    parameter int BASE_TICKS = `EAW_WDOG_BASE_MS * `EAW_WDOG_TICKS_PER_MS,
    parameter int CNT_W      = 24
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       osc_tick,
    input  wire logic       enable,
    input  wire logic       restart,
    input  wire logic       power_down,
    input  wire logic [2:0] period_sel,
    output logic            timeout
);
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] limit;
    logic             active;
    logic             timeout_reg, timeout_next;

    always_comb begin
        limit        = CNT_W'(BASE_TICKS) << period_sel;
        active       = enable && !power_down;
        cnt_next     = cnt_reg;
        timeout_next = 1'b0;
        if (!active || restart) begin
            cnt_next = '0;
        end else if (osc_tick) begin
            if (cnt_reg + CNT_W'(1) >= limit) begin
                cnt_next     = '0;
                timeout_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_reg     <= '0;
            timeout_reg <= 1'b0;
        end else begin
            cnt_reg     <= cnt_next;
            timeout_reg <= timeout_next;
        end
    end

    assign timeout = timeout_reg;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_last_tick;
        active && !restart && osc_tick && (cnt_reg + CNT_W'(1) == limit);
    endsequence

    a_off_clear: assert property (!active |=> cnt_reg == '0 && !timeout)
        else $error("watchdog counted while off");
    a_restart_clear: assert property (restart |=> cnt_reg == '0 && !timeout)
        else $error("restart did not clear watchdog");
    a_tick_only: assert property (active && !restart && !osc_tick |=> cnt_reg == $past(cnt_reg))
        else $error("watchdog moved without oscillator tick");
    a_period_hit: assert property (timeout |-> $past(cnt_reg) + CNT_W'(1) == $past(limit))
        else $error("watchdog period wrong");
    a_timeout_pulse: assert property (s_last_tick |=> timeout ##1 !timeout)
        else $error("watchdog reset pulse missing");
endmodule

// [tb/eaw_far_mem.sv]
`timescale 1ns/100ps
module eaw_far_mem (
    input  wire logic        clock,
    input  wire logic        sfs_ext_req,
    input  wire logic        sfs_ext_we,
    input  wire logic [7:0]  sfs_ext_addr,
    input  wire logic [7:0]  sfs_ext_wdata,
    output logic      [7:0]  sfs_ext_rdata,
    input  wire logic        ext_xd_req,
    input  wire logic        ext_xd_we,
    input  wire logic [15:0] ext_xd_addr,
    input  wire logic [7:0]  ext_xd_wdata,
    output logic      [7:0]  ext_xd_rdata
);
    logic [7:0] sfs_mem [256];
    logic [7:0] xd_mem  [256];
    logic [7:0] noise_reg = 8'h00;

    always @(posedge clock) begin
        noise_reg <= noise_reg + 8'h35;
        if (sfs_ext_req && sfs_ext_we) begin
            sfs_mem[sfs_ext_addr] <= sfs_ext_wdata;
        end
        if (ext_xd_req && ext_xd_we) begin
            xd_mem[ext_xd_addr[7:0]] <= ext_xd_wdata;
        end
    end

    // Idle read bus shows a moving pattern, so a stale byte never passes
    assign sfs_ext_rdata = sfs_ext_req ? sfs_mem[sfs_ext_addr] : noise_reg;
    assign ext_xd_rdata  = ext_xd_req ? xd_mem[ext_xd_addr[7:0]] : noise_reg;
endmodule

// [tb/eaw_top_tb.sv]
`timescale 1ns/100ps
`define chk(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module eaw_top_tb;
    localparam int EE_N = 20;
    localparam int WD_N = 2;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        id_req = 1'b0, id_we = 1'b0, id_indirect = 1'b0, id_stack = 1'b0;
    logic [7:0]  id_addr = 8'h00, id_wdata = 8'h00, id_rdata, sfs_ext_addr, sfs_ext_wdata, sfs_ext_rdata;
    logic        id_rvalid, sfs_ext_req, sfs_ext_we, xd_rvalid, ext_xd_req, ext_xd_we;
    logic        xd_req = 1'b0, xd_we = 1'b0, wdog_osc_tick = 1'b0, power_down = 1'b0;
    logic [15:0] xd_addr = 16'h0000, ext_xd_addr;
    logic [7:0]  xd_wdata = 8'h00, xd_rdata, ext_xd_wdata, ext_xd_rdata;
    logic        wdog_cpu_reset, eeprom_done_flag;
    logic [7:0]  r;
    int          n, mismatches = 0, samples_checked = 0, wd_pulses = 0;

    always #25 clock = ~clock;

    always @(posedge clock) begin
        if (wdog_cpu_reset === 1'b1) begin
            wd_pulses <= wd_pulses + 1;
        end
    end

    eaw_top #(.EE_WRITE_CYCLES(EE_N), .WDOG_BASE_TICKS(WD_N)) eaw_top_i (
        .clock, .rst, .id_req, .id_we, .id_indirect, .id_stack, .id_addr, .id_wdata, .id_rdata,
        .id_rvalid, .sfs_ext_req, .sfs_ext_we, .sfs_ext_addr, .sfs_ext_wdata, .sfs_ext_rdata,
        .xd_req, .xd_we, .xd_addr, .xd_wdata, .xd_rdata, .xd_rvalid, .ext_xd_req, .ext_xd_we,
        .ext_xd_addr, .ext_xd_wdata, .ext_xd_rdata, .wdog_osc_tick, .power_down, .wdog_cpu_reset,
        .eeprom_done_flag);

    eaw_far_mem eaw_far_mem_i (
        .clock, .sfs_ext_req, .sfs_ext_we, .sfs_ext_addr, .sfs_ext_wdata, .sfs_ext_rdata,
        .ext_xd_req, .ext_xd_we, .ext_xd_addr, .ext_xd_wdata, .ext_xd_rdata);

    // Mode bits are {stack, indirect, write}
    task automatic id_acc(input logic [2:0] m, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        #1;
        {id_stack, id_indirect, id_we} = m;
        id_addr = a;
        id_wdata = d;
        id_req = 1'b1;
        @(posedge clock);
        #1;
        id_req = 1'b0;
        q = id_rvalid ? id_rdata : 8'hxx;
    endtask

    // Indirect write then read of the same byte on back-to-back edges
    task automatic id_wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        #1;
        {id_stack, id_indirect, id_we} = 3'b011;
        id_addr = a;
        id_wdata = d;
        id_req = 1'b1;
        @(posedge clock);
        #1;
        id_we = 1'b0;
        @(posedge clock);
        #1;
        id_req = 1'b0;
        q = id_rvalid ? id_rdata : 8'hxx;
    endtask

    task automatic xd_acc(input logic we, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        #1;
        xd_we = we;
        xd_addr = a;
        xd_wdata = d;
        xd_req = 1'b1;
        @(posedge clock);
        #1;
        xd_req = 1'b0;
        q = xd_rvalid ? xd_rdata : 8'hxx;
    endtask

    task automatic wmc(input logic [7:0] v);
        logic [7:0] q;
        id_acc(3'b001, 8'h96, v, q);
    endtask

    task automatic wait_done(output int c);
        c = 0;
        while (eeprom_done_flag !== 1'b1 && c < 1000) begin
            @(posedge clock);
            #1;
            c++;
        end
    endtask

    // Two idle cycles after each tick let the registered pulse land
    task automatic tick1;
        @(posedge clock);
        #1;
        wdog_osc_tick = 1'b1;
        @(posedge clock);
        #1;
        wdog_osc_tick = 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic tick_chk(input int k, input int p);
        int p0;
        p0 = wd_pulses;
        repeat (k) tick1();
        `chk(wd_pulses - p0, p)
    endtask

    task automatic ticks_to_rst(output int c);
        int p0;
        p0 = wd_pulses;
        c = 0;
        while (wd_pulses == p0 && c < 600) begin
            tick1();
            c++;
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        mismatches++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge clock);
        #1;
        rst = 1'b0;
        id_acc(3'b000, 8'h96, 8'h00, r);
        `chk(r, 8'h02)
        id_acc(3'b001, 8'ha0, 8'h11, r);
        id_acc(3'b011, 8'ha0, 8'h22, r);
        id_acc(3'b000, 8'ha0, 8'h00, r);
        `chk(r, 8'h11)
        id_acc(3'b010, 8'ha0, 8'h00, r);
        `chk(r, 8'h22)
        id_acc(3'b100, 8'ha0, 8'h00, r);
        `chk(r, 8'h22)
        id_wr_rd(8'hc3, 8'h5c, r);
        `chk(r, 8'h5c)
        xd_acc(1'b1, 16'h0005, 8'h66, r);
        wmc(8'h08);
        xd_acc(1'b1, 16'h0005, 8'h77, r);
        `chk(eeprom_done_flag, 1'b1)
        wmc(8'h18);
        xd_acc(1'b1, 16'h0005, 8'h5a, r);
        `chk(eeprom_done_flag, 1'b0)
        xd_acc(1'b0, 16'h0003, 8'h00, r);
        `chk(r, 8'hda)
        id_acc(3'b000, 8'h96, 8'h00, r);
        `chk(r, 8'h18)
        wait_done(n);
        `chk(n, EE_N - 4)
        xd_acc(1'b0, 16'h0005, 8'h00, r);
        `chk(r, 8'h5a)
        xd_acc(1'b1, 16'h07ff, 8'h33, r);
        wait_done(n);
        `chk(n, EE_N)
        xd_acc(1'b0, 16'h07ff, 8'h00, r);
        `chk(r, 8'h33)
        xd_acc(1'b1, 16'h0800, 8'h44, r);
        `chk(eeprom_done_flag, 1'b1)
        xd_acc(1'b0, 16'h0800, 8'h00, r);
        `chk(r, 8'h44)
        wmc(8'h00);
        xd_acc(1'b0, 16'h0005, 8'h00, r);
        `chk(r, 8'h66)
        for (int c = 0; c < 8; c++) begin
            wmc({c[2:0], 5'h01});
            ticks_to_rst(n);
            `chk(n, WD_N << c)
            wmc(8'h00);
        end
        wmc(8'h01);
        repeat (100) @(posedge clock);
        tick_chk(1, 0);
        wmc(8'h03);
        tick_chk(1, 0);
        tick_chk(1, 1);
        tick_chk(1, 0);
        wmc(8'h00);
        wmc(8'h01);
        tick_chk(1, 0);
        tick_chk(1, 1);
        wmc(8'h00);
        tick_chk(3, 0);
        wmc(8'h01);
        power_down = 1'b1;
        tick_chk(3, 0);
        power_down = 1'b0;
        tick_chk(1, 0);
        tick_chk(1, 1);
        test_done();
    end
endmodule
